// ==== verilog/ssef_cfg.svh ====
// constants for the spi status and error flag block
`ifndef SSEF_CFG_SVH
`define SSEF_CFG_SVH
`define SSEF_DATA_W 8
`define SSEF_DATA_RST 8'h00
`define SSEF_FLAG_RST 1'h0
`define SSEF_SYNC_RST 2'h3
`endif

// ==== verilog/ssef_pkg.sv ====
// types for the spi status and error flag block
package ssef_pkg;
    typedef enum logic {
        SSEF_ROLE_SLAVE,
        SSEF_ROLE_MASTER
    } ssef_role_t;
endpackage

// ==== verilog/ssef_flags.sv ====
// spi status flags, collision, mode fault and interrupt request
`include "ssef_cfg.svh"

module ssef_flags
    import ssef_pkg::*;
#(
    parameter int DATA_W = `SSEF_DATA_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic data_wr,
    input wire logic [DATA_W-1:0] data_wdata,
    input wire logic data_rd,
    input wire logic ctrl_wr,
    input wire logic ctrl_master_in,
    input wire logic ctrl_enable_in,
    input wire logic ctrl_sel_oe_in,
    input wire logic ctrl_sel_ded_in,
    input wire logic collision_clr,
    input wire logic done_clr,
    input wire logic fault_clr,
    input wire logic ovf_clr,
    input wire logic serial_int_enable,
    input wire logic global_int_enable,
    input wire logic xfer_active,
    input wire logic xfer_done,
    input wire logic [DATA_W-1:0] rx_byte,
    input wire logic ss_n_pin,
    output logic [DATA_W-1:0] serial_data_reg,
    output logic [DATA_W-1:0] shift_load_data,
    output logic shift_load,
    output logic shift_start,
    output logic write_collision_flag,
    output logic transfer_done_flag,
    output logic mode_fault_flag,
    output logic receive_overrun_flag,
    output logic master_select,
    output logic port_enable,
    output logic select_output_enable,
    output logic select_pin_dedicate,
    output logic spi_irq
);
    logic [1:0] ss_sync_r;
    logic ss_low;
    logic busy;
    logic collide;
    logic fault;
    logic rx_keep;
    ssef_role_t role;

    // pin is asynchronous to clk; only the second stage is looked at
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ss_sync_r <= `SSEF_SYNC_RST;
        end else begin
            ss_sync_r <= {ss_sync_r[0], ss_n_pin};
        end
    end

    assign ss_low = !ss_sync_r[1];
    assign role = master_select ? SSEF_ROLE_MASTER : SSEF_ROLE_SLAVE;
    // a start issued last cycle counts as busy until the shifter reports it
    assign busy = xfer_active || shift_start;
    assign collide = data_wr && busy;
    assign fault = master_select && ss_low && !select_output_enable
        && !select_pin_dedicate;
    assign rx_keep = transfer_done_flag && !done_clr;

    // control bits; a fault overrides a software write to master_select and port_enable in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master_select <= `SSEF_FLAG_RST;
            port_enable <= `SSEF_FLAG_RST;
            select_output_enable <= `SSEF_FLAG_RST;
            select_pin_dedicate <= `SSEF_FLAG_RST;
        end else begin
            if (ctrl_wr) begin
                select_output_enable <= ctrl_sel_oe_in;
                select_pin_dedicate <= ctrl_sel_ded_in;
            end
            if (fault) begin
                master_select <= 1'h0;
                port_enable <= 1'h0;
            end else if (ctrl_wr) begin
                master_select <= ctrl_master_in;
                port_enable <= ctrl_enable_in;
            end
        end
    end

    // single-buffered transmit: an accepted write goes to the shifter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_load <= `SSEF_FLAG_RST;
            shift_start <= `SSEF_FLAG_RST;
            shift_load_data <= `SSEF_DATA_RST;
        end else begin
            shift_load <= data_wr && !collide;
            shift_start <= data_wr && !collide && port_enable
                && role == SSEF_ROLE_MASTER;
            if (data_wr && !collide) begin
                shift_load_data <= data_wdata;
            end
        end
    end

    // read buffer; software reading the byte is not enough, done must clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_data_reg <= `SSEF_DATA_RST;
        end else if (xfer_done && !rx_keep) begin
            serial_data_reg <= rx_byte;
        end
    end

    // sticky flags: set beats clear when both land together
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            write_collision_flag <= `SSEF_FLAG_RST;
            transfer_done_flag <= `SSEF_FLAG_RST;
            mode_fault_flag <= `SSEF_FLAG_RST;
            receive_overrun_flag <= `SSEF_FLAG_RST;
        end else begin
            if (collide) begin
                write_collision_flag <= 1'h1;
            end else if (collision_clr) begin
                write_collision_flag <= 1'h0;
            end
            if (xfer_done && !rx_keep) begin
                transfer_done_flag <= 1'h1;
            end else if (done_clr) begin
                transfer_done_flag <= 1'h0;
            end
            if (fault) begin
                mode_fault_flag <= 1'h1;
            end else if (fault_clr) begin
                mode_fault_flag <= 1'h0;
            end
            if (xfer_done && rx_keep) begin
                receive_overrun_flag <= 1'h1;
            end else if (ovf_clr) begin
                receive_overrun_flag <= 1'h0;
            end
        end
    end

    // request is a level that follows the done and mode fault flags one cycle late
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            spi_irq <= `SSEF_FLAG_RST;
        end else begin
            spi_irq <= serial_int_enable && ((transfer_done_flag
                && global_int_enable) || mode_fault_flag);
        end
    end

    property p_collision_set;
        @(posedge clk) disable iff (!nrst)
        (data_wr && (xfer_active || shift_start)) |=> write_collision_flag;
    endproperty
    a_collision_set: assert property (p_collision_set)
        else $error("write collision not flagged");

    property p_collide_no_load;
        @(posedge clk) disable iff (!nrst)
        (data_wr && xfer_active) |=> !shift_load && !shift_start;
    endproperty
    a_collide_no_load: assert property (p_collide_no_load)
        else $error("colliding write reached the shifter");

    property p_load_data;
        @(posedge clk) disable iff (!nrst)
        (data_wr && !xfer_active && !shift_start)
            |=> shift_load && shift_load_data == $past(data_wdata);
    endproperty
    a_load_data: assert property (p_load_data)
        else $error("accepted write not loaded");

    property p_collision_sticky;
        @(posedge clk) disable iff (!nrst)
        (write_collision_flag && !collision_clr) |=> write_collision_flag;
    endproperty
    a_collision_sticky: assert property (p_collision_sticky)
        else $error("collision flag dropped by itself");

    property p_done_copy;
        @(posedge clk) disable iff (!nrst)
        (xfer_done && !transfer_done_flag) |=> transfer_done_flag
            && serial_data_reg == $past(rx_byte);
    endproperty
    a_done_copy: assert property (p_done_copy)
        else $error("received byte not captured");

    property p_irq_done;
        @(posedge clk) disable iff (!nrst)
        (transfer_done_flag && serial_int_enable && global_int_enable)
            |=> spi_irq;
    endproperty
    a_irq_done: assert property (p_irq_done)
        else $error("done request missing");

    property p_irq_gate;
        @(posedge clk) disable iff (!nrst)
        !serial_int_enable |=> !spi_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request raised while disabled");

    property p_fault_drop;
        @(posedge clk) disable iff (!nrst)
        (master_select && !ss_sync_r[1] && !select_output_enable
            && !select_pin_dedicate)
            |=> mode_fault_flag && !master_select && !port_enable;
    endproperty
    a_fault_drop: assert property (p_fault_drop)
        else $error("mode fault did not release master");

    property p_no_fault_out;
        @(posedge clk) disable iff (!nrst)
        (!mode_fault_flag && (select_output_enable || select_pin_dedicate)
            && !ctrl_wr) |=> !mode_fault_flag;
    endproperty
    a_no_fault_out: assert property (p_no_fault_out)
        else $error("mode fault with select as output");

    property p_overrun_keep;
        @(posedge clk) disable iff (!nrst)
        (xfer_done && transfer_done_flag && !done_clr)
            |=> receive_overrun_flag && $stable(serial_data_reg);
    endproperty
    a_overrun_keep: assert property (p_overrun_keep)
        else $error("overrun lost the previous byte");

    property p_set_wins;
        @(posedge clk) disable iff (!nrst)
        (data_wr && xfer_active && collision_clr) |=> write_collision_flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a collision");

    c_collision: cover property (@(posedge clk) disable iff (!nrst)
        data_wr && xfer_active);
    c_overrun: cover property (@(posedge clk) disable iff (!nrst)
        xfer_done && transfer_done_flag);
    c_fault: cover property (@(posedge clk) disable iff (!nrst)
        $rose(mode_fault_flag));
endmodule

// ==== testbench/ssef_shift_model.sv ====
// far-side shifter model: one byte of eight 80 ns bits per start
module ssef_shift_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [7:0] rx_value,
    output logic xfer_active,
    output logic xfer_done,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] cnt_r;
    assign xfer_active = (cnt_r != 7'h00);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 7'h00;
            xfer_done <= 1'h0;
            rx_byte <= 8'h00;
        end else begin
            xfer_done <= (cnt_r == 7'h01);
            // byte only valid with done; otherwise it keeps changing
            rx_byte <= (cnt_r == 7'h01) ? rx_value : ~rx_byte;
            // a start while busy is ignored, like a real shifter
            if (go && cnt_r == 7'h00) begin
                cnt_r <= 7'h40;
            end else if (cnt_r != 7'h00) begin
                cnt_r <= cnt_r - 7'h01;
            end
        end
    end
endmodule

// ==== testbench/tb.sv ====
// bench for the spi status and error flag block
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin \
    miscompares++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, nrst = 1'h0, data_wr = 1'h0, data_rd = 1'h0;
    logic ctrl_wr = 1'h0, ctrl_master_in = 1'h0, ctrl_enable_in = 1'h0;
    logic ctrl_sel_oe_in = 1'h0, ctrl_sel_ded_in = 1'h0, collision_clr = 1'h0;
    logic done_clr = 1'h0, fault_clr = 1'h0, ovf_clr = 1'h0, go_slave = 1'h0;
    logic serial_int_enable = 1'h0, global_int_enable = 1'h0, ss_n_pin = 1'h1;
    logic xfer_active, xfer_done, shift_load, shift_start, spi_irq;
    logic write_collision_flag, transfer_done_flag, mode_fault_flag;
    logic receive_overrun_flag, master_select, port_enable;
    logic select_output_enable, select_pin_dedicate;
    logic [7:0] data_wdata = 8'h00, rx_value = 8'h00, rx_byte;
    logic [7:0] serial_data_reg, shift_load_data;
    int miscompares = 0, check_count = 0, cyc = 0;
    ssef_flags dut (.clk, .nrst, .data_wr, .data_wdata, .data_rd, .ctrl_wr,
        .ctrl_master_in, .ctrl_enable_in, .ctrl_sel_oe_in, .ctrl_sel_ded_in,
        .collision_clr, .done_clr, .fault_clr, .ovf_clr, .serial_int_enable,
        .global_int_enable, .xfer_active, .xfer_done, .rx_byte, .ss_n_pin,
        .serial_data_reg, .shift_load_data, .shift_load, .shift_start,
        .write_collision_flag, .transfer_done_flag, .mode_fault_flag,
        .receive_overrun_flag, .master_select, .port_enable,
        .select_output_enable, .select_pin_dedicate, .spi_irq);
    ssef_shift_model far (.clk, .nrst, .go(shift_start | go_slave),
        .rx_value, .xfer_active, .xfer_done, .rx_byte);
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        data_wr <= 1'h1;
        data_wdata <= d;
        @(posedge clk);
        data_wr <= 1'h0;
        #1;
    endtask
    task automatic ctl(input logic m, e, o, d);
        @(posedge clk);
        ctrl_wr <= 1'h1;
        {ctrl_master_in, ctrl_enable_in} <= {m, e};
        {ctrl_sel_oe_in, ctrl_sel_ded_in} <= {o, d};
        @(posedge clk);
        ctrl_wr <= 1'h0;
        #1;
    endtask
    task automatic clr(input logic w, d, m, o);
        @(posedge clk);
        {collision_clr, done_clr, fault_clr, ovf_clr} <= {w, d, m, o};
        @(posedge clk);
        {collision_clr, done_clr, fault_clr, ovf_clr} <= 4'h0;
        #1;
    endtask
    // bounded; the cycle ceiling catches a shifter that never finishes
    task automatic wait_xfer();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (xfer_done !== 1'h1 && n < 200);
        @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        #1;
        `CHK("reset", {write_collision_flag, transfer_done_flag, spi_irq}, 3'h0)
        ctl(1'h1, 1'h1, 1'h0, 1'h1);
        @(posedge clk);
        serial_int_enable <= 1'h1;
        global_int_enable <= 1'h1;
        rx_value <= 8'h3C;
        wr(8'hA5);
        `CHK("load", {shift_load, shift_load_data}, 9'h1A5)
        `CHK("start", shift_start, 1'h1)
        wr(8'h5A);
        `CHK("collision", write_collision_flag, 1'h1)
        `CHK("drop", {shift_load, shift_load_data}, 9'h0A5)
        wait_xfer();
        `CHK("rx", {transfer_done_flag, serial_data_reg}, 9'h13C)
        `CHK("coll_hold", write_collision_flag, 1'h1)
        @(posedge clk);
        #1;
        `CHK("irq", spi_irq, 1'h1)
        @(posedge clk) global_int_enable <= 1'h0;
        @(posedge clk);
        #1;
        `CHK("irq_gie", spi_irq, 1'h0)
        rx_value <= 8'hC3;
        wr(8'h11);
        wait_xfer();
        `CHK("ovf", {receive_overrun_flag, serial_data_reg}, 9'h13C)
        `CHK("done_hold", transfer_done_flag, 1'h1)
        clr(1'h1, 1'h1, 1'h0, 1'h1);
        `CHK("cleared", {write_collision_flag, transfer_done_flag}, 2'h0)
        `CHK("ovf_clr", receive_overrun_flag, 1'h0)
        ctl(1'h0, 1'h1, 1'h0, 1'h0);
        rx_value <= 8'h96;
        wr(8'h77);
        `CHK("slv_load", {shift_load, shift_start}, 2'h2)
        @(posedge clk) go_slave <= 1'h1;
        @(posedge clk) go_slave <= 1'h0;
        @(posedge clk);
        data_wr <= 1'h1;
        collision_clr <= 1'h1;
        @(posedge clk);
        data_wr <= 1'h0;
        collision_clr <= 1'h0;
        #1;
        `CHK("slv_coll", write_collision_flag, 1'h1)
        wait_xfer();
        `CHK("slv_rx", serial_data_reg, 8'h96)
        clr(1'h1, 1'h1, 1'h0, 1'h0);
        ctl(1'h1, 1'h1, 1'h1, 1'h1);
        @(posedge clk) ss_n_pin <= 1'h0;
        repeat (4) @(posedge clk);
        #1;
        `CHK("no_fault", {mode_fault_flag, master_select}, 2'h1)
        `CHK("sel", {select_output_enable, select_pin_dedicate}, 2'h3)
        ctl(1'h1, 1'h1, 1'h0, 1'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK("fault", mode_fault_flag, 1'h1)
        `CHK("drop_mst", {master_select, port_enable}, 2'h0)
        `CHK("flt_irq", spi_irq, 1'h1)
        @(posedge clk) ss_n_pin <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("flt_hold", mode_fault_flag, 1'h1)
        clr(1'h0, 1'h0, 1'h1, 1'h0);
        `CHK("flt_clr", mode_fault_flag, 1'h0)
        wrap_up();
    end
endmodule
